/* File: core/iapg_cfg.svh */
// Register map, page layout and reset values
`ifndef IAPG_CFG_SVH
`define IAPG_CFG_SVH

// ****************************************
// Main register space
// ****************************************
`define IAPG_REG_TARGET_ID 8'h00
`define IAPG_REG_BLOCK_SEL 8'hB0
`define IAPG_REG_OFFSET 8'hB1
`define IAPG_REG_DATA 8'hB2
`define IAPG_RD_UNMAPPED 8'h00

// ****************************************
// Block select fields
// ****************************************
`define IAPG_AINC_BIT 1
`define IAPG_BLK_LSB 2
`define IAPG_BLK_W 3
`define IAPG_BLK_PGEN 3'h0

// ****************************************
// Pattern page
// ****************************************
`define IAPG_PAGE_DEPTH 32
`define IAPG_PAGE_AW 5
`define IAPG_PG_CTL 5'h01
`define IAPG_PG_CFG 5'h02
`define IAPG_PG_DT 5'h03
`define IAPG_PG_LINE_SIZE 5'h04
`define IAPG_PG_BAR_SIZE 5'h05
`define IAPG_PG_ACT_LINES 5'h06
`define IAPG_PG_TOT_LINES 5'h07
`define IAPG_PG_LINE_PD 5'h08
`define IAPG_PG_VBP 5'h09
`define IAPG_PG_VFP 5'h0A
`define IAPG_PG_BAR0 5'h10
`define IAPG_CTL_EN_BIT 0
`define IAPG_CTL_SEL_BIT 1
`define IAPG_CTL_MODE40_BIT 2
`define IAPG_CTL_SRC_LSB 3
`define IAPG_CFG_FIXED_BIT 3
`define IAPG_CFG_BLK_LSB 4
`define IAPG_DT_RESET 8'h24
`define IAPG_PAGE_RESET 8'h00

// ****************************************
// Clock sources
// ****************************************
`define IAPG_NSRC 3
`define IAPG_SRC_BC 2'h0
`define IAPG_SRC_CSI 2'h1
`define IAPG_SRC_EXT 2'h2

`endif

/* File: core/iapg_pkg.sv */
// Types shared by both ends of the indirect access link
package iapg_pkg;
`include "iapg_cfg.svh"

    typedef enum logic [1:0] {
        IAPG_IDLE = 2'h0,
        IAPG_CTL = 2'h1,
        IAPG_ADDR = 2'h3,
        IAPG_DATA = 2'h2
    } iapg_step_type;

    typedef struct packed {
        logic [`IAPG_NSRC-1:0][2:0] sync;
        logic [`IAPG_NSRC-1:0] lvl;
        logic strap_done;
        logic [7:0] target_id;
        logic [7:0] block_sel;
        logic [7:0] offset;
        logic [`IAPG_PAGE_DEPTH-1:0][7:0] page;
        logic ack;
        logic [7:0] rdata;
        logic [7:0] px;
        logic [7:0] ln;
        logic [7:0] bar_cnt;
        logic [2:0] bar;
        logic [31:0] word;
        logic valid;
        logic [39:0] path;
        logic path_valid;
        logic [7:0] dtype;
    } iapg_dev_type;

    typedef struct packed {
        iapg_step_type step;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] block;
        logic [7:0] offset;
        logic [7:0] value;
        logic write;
        logic rsp;
        logic [7:0] rdata;
    } iapg_host_type;
endpackage

/* File: core/iapg_if.sv */
// Register access link between the configuring host and the device
`timescale 1ns/1ns
interface iapg_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport device (input req, input we, input addr, input wdata, output rdata, output ack);
    modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

/* File: core/iapg_dev.sv */
// Device end: main registers, indirect pattern page, pattern generator and output mux
`timescale 1ns/1ns
`include "iapg_cfg.svh"
module iapg_dev (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register link
    iapg_if.device bus,
    // Strap and clock source pins
    input wire logic [6:0] address_strap_pin_i,
    input wire logic bc_clk_i,
    input wire logic csi_clk_i,
    input wire logic ext_clk_i,
    // Parallel CSI-2 data
    input wire logic [31:0] csi_data_i,
    input wire logic csi_valid_i,
    input wire logic [7:0] csi_dt_i,
    // Transmit data path
    output logic [39:0] tx_path_o,
    output logic tx_valid_o,
    output logic tx_mode40_o,
    output logic [7:0] tx_dt_o,
    output logic [31:0] pgen_word_o,
    output logic pgen_valid_o,
    output logic [7:0] target_id_o
);
    iapg_pkg::iapg_dev_type st;
    iapg_pkg::iapg_dev_type next_st;

    logic [`IAPG_NSRC-1:0] pin;
    logic [7:0] ctl;
    logic [7:0] cfg;
    logic [2:0] nbars_m1;
    logic [7:0] bar_w;
    logic [8:0] act_end;
    logic [8:0] frame_end;
    logic tick;
    logic active;
    logic pgen_blk;
    logic ainc;
    logic take;
    logic [`IAPG_PAGE_AW-1:0] idx;

    assign pin = {ext_clk_i, csi_clk_i, bc_clk_i};
    assign ctl = st.page[`IAPG_PG_CTL];
    assign cfg = st.page[`IAPG_PG_CFG];
    assign nbars_m1 = cfg[2:0];
    assign pgen_blk = st.block_sel[`IAPG_BLK_LSB +: `IAPG_BLK_W] == `IAPG_BLK_PGEN;
    assign ainc = st.block_sel[`IAPG_AINC_BIT];
    assign idx = st.offset[`IAPG_PAGE_AW-1:0];
    assign take = bus.req && !st.ack;
    // Fixed pattern uses the block size as bar width
    assign bar_w = cfg[`IAPG_CFG_FIXED_BIT] ? {4'h0, cfg[`IAPG_CFG_BLK_LSB +: 4]} :
        st.page[`IAPG_PG_BAR_SIZE];
    assign act_end = {1'b0, st.page[`IAPG_PG_VBP]} + {1'b0, st.page[`IAPG_PG_ACT_LINES]};
    assign frame_end = act_end + {1'b0, st.page[`IAPG_PG_VFP]};

    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.valid = 1'b0;

        // ****************************************
        // Clock source pins: three stages, level once two and three agree
        // ****************************************
        for (int i = 0; i < `IAPG_NSRC; i++) begin
            next_st.sync[i] = {st.sync[i][1:0], pin[i]};
            if (st.sync[i][1] == st.sync[i][2]) begin
                next_st.lvl[i] = st.sync[i][2];
            end
        end
        tick = 1'b0;
        unique case (ctl[`IAPG_CTL_SRC_LSB +: 2])
            `IAPG_SRC_CSI: tick = next_st.lvl[1] && !st.lvl[1];
            `IAPG_SRC_EXT: tick = next_st.lvl[2] && !st.lvl[2];
            default: tick = next_st.lvl[0] && !st.lvl[0];
        endcase

        // ****************************************
        // Strap capture after reset release
        // ****************************************
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            next_st.target_id = {1'b0, address_strap_pin_i};
        end

        // ****************************************
        // Register link
        // ****************************************
        if (take) begin
            next_st.ack = 1'b1;
            next_st.rdata = `IAPG_RD_UNMAPPED;
            unique case (bus.addr)
                `IAPG_REG_TARGET_ID: begin
                    next_st.rdata = st.target_id;
                    if (bus.we) begin
                        next_st.target_id = bus.wdata;
                    end
                end
                `IAPG_REG_BLOCK_SEL: begin
                    next_st.rdata = st.block_sel;
                    if (bus.we) begin
                        next_st.block_sel = bus.wdata;
                    end
                end
                `IAPG_REG_OFFSET: begin
                    next_st.rdata = st.offset;
                    if (bus.we) begin
                        next_st.offset = bus.wdata;
                    end
                end
                `IAPG_REG_DATA: begin
                    // Other blocks are not built here: they read zero and drop writes
                    next_st.rdata = pgen_blk ? st.page[idx] : `IAPG_RD_UNMAPPED;
                    if (bus.we && pgen_blk) begin
                        next_st.page[idx] = bus.wdata;
                    end
                    // Offset held unless auto-increment set
                    if (ainc) begin
                        next_st.offset = st.offset + 8'h01;
                    end
                end
                default: begin
                    next_st.rdata = `IAPG_RD_UNMAPPED;
                end
            endcase
        end

        // ****************************************
        // Pattern generator
        // ****************************************
        active = (st.ln >= st.page[`IAPG_PG_VBP]) && ({1'b0, st.ln} < act_end) &&
            (st.px < st.page[`IAPG_PG_LINE_SIZE]);
        if (!ctl[`IAPG_CTL_EN_BIT]) begin
            next_st.px = 8'h00;
            next_st.ln = 8'h00;
            next_st.bar_cnt = 8'h00;
            next_st.bar = 3'h0;
        end else if (tick) begin
            if (active) begin
                next_st.word = {4{st.page[`IAPG_PG_BAR0 + {2'h0, st.bar}]}};
                next_st.valid = 1'b1;
                if (st.bar_cnt + 8'h01 >= bar_w) begin
                    next_st.bar_cnt = 8'h00;
                    next_st.bar = (st.bar >= nbars_m1) ? 3'h0 : st.bar + 3'h1;
                end else begin
                    next_st.bar_cnt = st.bar_cnt + 8'h01;
                end
            end
            if (st.px + 8'h01 >= st.page[`IAPG_PG_LINE_PD]) begin
                next_st.px = 8'h00;
                next_st.bar_cnt = 8'h00;
                next_st.bar = 3'h0;
                // Frame ends at total lines or at back porch plus active lines plus front porch, whichever first
                if (st.ln + 8'h01 >= st.page[`IAPG_PG_TOT_LINES] ||
                    {1'b0, st.ln} + 9'h001 >= frame_end) begin
                    next_st.ln = 8'h00;
                end else begin
                    next_st.ln = st.ln + 8'h01;
                end
            end else begin
                next_st.px = st.px + 8'h01;
            end
        end

        // ****************************************
        // Source mux and data path mode
        // ****************************************
        if (ctl[`IAPG_CTL_SEL_BIT]) begin
            next_st.path_valid = st.valid;
            next_st.dtype = st.page[`IAPG_PG_DT];
            next_st.path = ctl[`IAPG_CTL_MODE40_BIT] ? {8'h00, st.word} : {12'h000, st.word[27:0]};
        end else begin
            next_st.path_valid = csi_valid_i;
            next_st.dtype = csi_dt_i;
            next_st.path = ctl[`IAPG_CTL_MODE40_BIT] ? {8'h00, csi_data_i} : {12'h000, csi_data_i[27:0]};
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
            for (int i = 0; i < `IAPG_PAGE_DEPTH; i++) begin
                st.page[i] <= `IAPG_PAGE_RESET;
            end
            st.page[`IAPG_PG_DT] <= `IAPG_DT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign bus.ack = st.ack;
    assign bus.rdata = st.rdata;
    assign tx_path_o = st.path;
    assign tx_valid_o = st.path_valid;
    assign tx_mode40_o = ctl[`IAPG_CTL_MODE40_BIT];
    assign tx_dt_o = st.dtype;
    assign pgen_word_o = st.word;
    assign pgen_valid_o = st.valid;
    assign target_id_o = st.target_id;
endmodule

/* File: core/iapg_host.sv */
// Host end: turns indirect user commands into the block, offset, data register sequence; burst and direct ones take a single access
`timescale 1ns/1ns
`include "iapg_cfg.svh"
module iapg_host (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register link
    iapg_if.host bus,
    // User command
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_indirect_i,
    input wire logic cmd_burst_i,
    input wire logic [7:0] cmd_block_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic cmd_ready_o,
    // User answer
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o
);
    iapg_pkg::iapg_host_type st;
    iapg_pkg::iapg_host_type next_st;

    assign cmd_ready_o = (st.step == iapg_pkg::IAPG_IDLE);

    always_comb begin
        next_st = st;
        next_st.rsp = 1'b0;
        unique case (st.step)
            iapg_pkg::IAPG_IDLE: begin
                if (cmd_valid_i) begin
                    next_st.block = cmd_block_i;
                    next_st.offset = cmd_addr_i;
                    next_st.value = cmd_wdata_i;
                    next_st.write = cmd_write_i;
                    next_st.req = 1'b1;
                    if (!cmd_indirect_i) begin
                        next_st.step = iapg_pkg::IAPG_DATA;
                        next_st.addr = cmd_addr_i;
                        next_st.we = cmd_write_i;
                        next_st.wdata = cmd_wdata_i;
                    end else if (cmd_burst_i) begin
                        // Offset left to the device's auto-increment
                        next_st.step = iapg_pkg::IAPG_DATA;
                        next_st.addr = `IAPG_REG_DATA;
                        next_st.we = cmd_write_i;
                        next_st.wdata = cmd_wdata_i;
                    end else begin
                        next_st.step = iapg_pkg::IAPG_CTL;
                        next_st.addr = `IAPG_REG_BLOCK_SEL;
                        next_st.we = 1'b1;
                        next_st.wdata = cmd_block_i;
                    end
                end
            end
            iapg_pkg::IAPG_CTL: begin
                if (bus.ack) begin
                    next_st.step = iapg_pkg::IAPG_ADDR;
                    next_st.addr = `IAPG_REG_OFFSET;
                    next_st.we = 1'b1;
                    next_st.wdata = st.offset;
                    next_st.req = 1'b0;
                end else begin
                    next_st.req = 1'b1;
                end
            end
            iapg_pkg::IAPG_ADDR: begin
                if (bus.ack) begin
                    next_st.step = iapg_pkg::IAPG_DATA;
                    next_st.addr = `IAPG_REG_DATA;
                    next_st.we = st.write;
                    next_st.wdata = st.value;
                    next_st.req = 1'b0;
                end else begin
                    next_st.req = 1'b1;
                end
            end
            iapg_pkg::IAPG_DATA: begin
                if (bus.ack) begin
                    next_st.step = iapg_pkg::IAPG_IDLE;
                    next_st.req = 1'b0;
                    next_st.rsp = 1'b1;
                    next_st.rdata = bus.rdata;
                end else begin
                    next_st.req = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.req = st.req;
    assign bus.we = st.we;
    assign bus.addr = st.addr;
    assign bus.wdata = st.wdata;
    assign rsp_valid_o = st.rsp;
    assign rsp_data_o = st.rdata;
endmodule

/* File: testbench/iapg_assertions.sv */
// Checker for the register link between the host and device ends
`timescale 1ns/1ns
`include "iapg_cfg.svh"
module iapg_assertions (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [7:0] blk;
    logic [7:0] off;
    logic seen;
    // ****************************************
    // Shadow of block select and offset
    // ****************************************
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blk <= 8'h00;
            off <= 8'h00;
            seen <= 1'b0;
        end else if (ack && we && addr == `IAPG_REG_BLOCK_SEL) begin
            blk <= wdata;
        end else if (ack && we && addr == `IAPG_REG_OFFSET) begin
            off <= wdata;
            seen <= 1'b1;
        end else if (ack && addr == `IAPG_REG_DATA && blk[`IAPG_AINC_BIT]) begin
            off <= off + 8'h01;
        end
    end
    sequence s_take;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 (!ack && !req);
    endsequence
    a_ack_after_take: assert property (s_take |=> s_answer)
        else $error("ack not one cycle after request");
    a_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
        else $error("ack without a taken request");
    a_req_held: assert property (s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    a_unmapped_zero: assert property (ack && !we && !(addr inside {`IAPG_REG_TARGET_ID, `IAPG_REG_BLOCK_SEL,
        `IAPG_REG_OFFSET, `IAPG_REG_DATA}) |-> rdata == `IAPG_RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_block_readback: assert property (ack && !we && addr == `IAPG_REG_BLOCK_SEL |-> rdata == blk)
        else $error("block select readback wrong");
    a_offset_tracks: assert property (ack && !we && addr == `IAPG_REG_OFFSET |-> rdata == off)
        else $error("offset readback wrong");
    a_rdata_holds: assert property (!ack |-> $stable(rdata))
        else $error("read data moved without ack");
    a_setup_first: assert property (req && !ack && addr == `IAPG_REG_DATA |-> seen)
        else $error("data access before offset set");
endmodule

/* File: testbench/tb_indirect_access_pattern_gen.sv */
// Testbench joining the host and device ends over the register link
`timescale 1ns/1ns
`define TB_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_indirect_access_pattern_gen;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [6:0] strap = 7'h00;
    logic [2:0] pins = 3'h0;
    logic [31:0] csi_d = 32'h0000_0000;
    logic csi_v = 1'b0;
    logic [7:0] csi_dt = 8'h00;
    logic c_v = 1'b0, c_w = 1'b0, c_ind = 1'b0, c_bst = 1'b0;
    logic [7:0] c_blk = 8'h00, c_a = 8'h00, c_d = 8'h00;
    logic c_rdy, r_v, tx_v, tx_m40, pg_v;
    logic [7:0] r_d, tid_o, tx_dt, got, b;
    logic [39:0] tx_p;
    logic [31:0] pg_w;
    logic [7:0] cfgv [8] = '{8'h24, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
    logic [31:0] lf = 32'd89476;
    int err_count = 0;
    int comparisons = 0;
    int pg [32];
    int m_blk = 0, m_off = 0, m_tid = 0, exp = 0;
    iapg_if lnk ();
    iapg_dev u_iapg_dev (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(lnk), .address_strap_pin_i(strap),
        .bc_clk_i(pins[0]), .csi_clk_i(pins[1]), .ext_clk_i(pins[2]), .csi_data_i(csi_d), .csi_valid_i(csi_v),
        .csi_dt_i(csi_dt), .tx_path_o(tx_p), .tx_valid_o(tx_v), .tx_mode40_o(tx_m40), .tx_dt_o(tx_dt),
        .pgen_word_o(pg_w), .pgen_valid_o(pg_v), .target_id_o(tid_o));
    iapg_host u_iapg_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(lnk), .cmd_valid_i(c_v),
        .cmd_write_i(c_w), .cmd_indirect_i(c_ind), .cmd_burst_i(c_bst), .cmd_block_i(c_blk), .cmd_addr_i(c_a),
        .cmd_wdata_i(c_d), .cmd_ready_o(c_rdy), .rsp_valid_o(r_v), .rsp_data_o(r_d));
    iapg_assertions u_iapg_assertions (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req(lnk.req), .we(lnk.we),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
    function automatic logic [7:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // One host command plus the reference model
    // ****************************************
    task automatic acc(input logic w, input logic ind, input logic bst, input logic [7:0] bk,
        input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge mclk_i);
        #2;
        {c_w, c_ind, c_bst, c_blk, c_a, c_d} = {w, ind, bst, bk, a, d};
        c_v = 1'b1;
        @(posedge mclk_i);
        #2;
        c_v = 1'b0;
        for (i = 0; i < 30 && r_v !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        `TB_CHK(r_v, 1'b1)
        got = r_d;
        if (ind) begin
            if (!bst) begin
                m_blk = bk;
                m_off = a;
            end
            exp = ((m_blk >> 2) % 8 == 0) ? pg[m_off % 32] : 0;
            if (w && (m_blk >> 2) % 8 == 0) pg[m_off % 32] = d;
            if (m_blk & 2) m_off = (m_off + 1) % 256;
        end else begin
            exp = (a == `IAPG_REG_BLOCK_SEL) ? m_blk : (a == `IAPG_REG_OFFSET) ? m_off :
                (a == `IAPG_REG_TARGET_ID) ? m_tid : 0;
        end
        `TB_CHK(got, exp[7:0])
    endtask
    // Pin held well past three clocks so the synchroniser sees both levels
    task automatic step(input int s, input logic m40);
        int i;
        @(posedge mclk_i);
        #2;
        pins[s] = 1'b1;
        for (i = 0; i < 20 && pg_v !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        `TB_CHK(pg_v, 1'b1)
        `TB_CHK(pg_w, {4{b}})
        @(posedge mclk_i);
        #1;
        `TB_CHK(tx_v, 1'b1)
        `TB_CHK(tx_dt, pg[3][7:0])
        `TB_CHK(tx_p, m40 ? {8'h00, {4{b}}} : {12'h000, b[3:0], {3{b}}})
        `TB_CHK(tx_m40, m40)
        #1;
        pins[s] = 1'b0;
        repeat (6) @(posedge mclk_i);
    endtask
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    initial begin
        #(20 * 20000);
        err_count++;
        final_report();
    end
    initial begin
        for (int k = 0; k < 32; k++) pg[k] = 0;
        pg[3] = 8'h24;
        got = rnd();
        strap = got[6:0];
        m_tid = strap;
        repeat (8) @(posedge mclk_i);
        #2;
        reset_n_i = 1'b1;
        acc('0, '0, '0, '0, `IAPG_REG_TARGET_ID, '0);
        `TB_CHK(got, exp[7:0])
        `TB_CHK(tid_o, m_tid[7:0])
        acc('0, '1, '0, 8'h02, 8'h03, '0);
        `TB_CHK(got, exp[7:0])
        acc('0, '0, '0, '0, 8'h55, '0);
        `TB_CHK(got, exp[7:0])
        $display("test reset done");
        acc('1, '1, '0, 8'h02, 8'h10, rnd());
        for (int k = 1; k < 8; k++) acc('1, '1, '1, '0, '0, rnd());
        acc('0, '0, '0, '0, `IAPG_REG_OFFSET, '0);
        `TB_CHK(got, exp[7:0])
        acc('0, '1, '0, 8'h02, 8'h10, '0);
        `TB_CHK(got, exp[7:0])
        for (int k = 1; k < 8; k++) begin
            acc('0, '1, '1, '0, '0, '0);
            `TB_CHK(got, exp[7:0])
        end
        $display("test auto increment done");
        acc('1, '1, '0, 8'h00, 8'h0C, rnd());
        acc('1, '1, '1, '0, '0, rnd());
        acc('0, '0, '0, '0, `IAPG_REG_OFFSET, '0);
        `TB_CHK(got, exp[7:0])
        acc('0, '1, '0, 8'h00, 8'h0C, '0);
        `TB_CHK(got, exp[7:0])
        acc('0, '1, '0, 8'h06, 8'h10, '0);
        `TB_CHK(got, exp[7:0])
        acc('0, '0, '0, '0, `IAPG_REG_OFFSET, '0);
        `TB_CHK(got, exp[7:0])
        $display("test fixed offset done");
        acc('1, '1, '0, 8'h02, 8'h02, 8'h00);
        for (int k = 0; k < 8; k++) acc('1, '1, '1, '0, '0, cfgv[k]);
        b = rnd() | 8'h01;
        acc('1, '1, '0, 8'h02, 8'h10, b);
        for (int s = 0; s < 3; s++) begin
            acc('1, '1, '0, 8'h02, 8'h01, 8'h07 | 8'(s << 3));
            step(s, 1'b1);
        end
        acc('1, '1, '0, 8'h02, 8'h01, 8'h03);
        step(0, 1'b0);
        // Zero line size: a step must give no word
        acc('1, '1, '0, 8'h02, 8'h04, 8'h00);
        @(posedge mclk_i);
        #2;
        pins[0] = 1'b1;
        b = 8'h00;
        repeat (8) begin
            @(posedge mclk_i);
            #1;
            if (pg_v === 1'b1) b = b + 8'h01;
        end
        `TB_CHK(b, 8'h00)
        #1;
        pins[0] = 1'b0;
        repeat (6) @(posedge mclk_i);
        $display("test generator done");
        acc('1, '1, '0, 8'h02, 8'h01, 8'h05);
        @(posedge mclk_i);
        #2;
        csi_d = {rnd(), rnd(), rnd(), rnd()};
        csi_dt = rnd();
        csi_v = 1'b1;
        @(posedge mclk_i);
        #1;
        `TB_CHK(tx_v, 1'b1)
        `TB_CHK(tx_p, {8'h00, csi_d})
        `TB_CHK(tx_dt, csi_dt)
        #1;
        csi_v = 1'b0;
        $display("test parallel path done");
        final_report();
    end
endmodule
